// ---- common/isc_pkg.sv ----
// Constants and carrier types of the sweep control decoder
package isc_pkg;
   // Byte addresses on the register port
   localparam logic [7:0] ISC_ADDR_CTRL_HI = 8'h80;
   localparam logic [7:0] ISC_ADDR_CTRL_LO = 8'h81;
   localparam logic [7:0] ISC_ADDR_INDEX_HI = 8'h90;
   localparam logic [7:0] ISC_ADDR_INDEX_LO = 8'h91;
   localparam logic [7:0] ISC_ADDR_REAL_HI = 8'h94;
   localparam logic [7:0] ISC_ADDR_REAL_LO = 8'h95;
   localparam logic [7:0] ISC_ADDR_IMAG_HI = 8'h96;
   localparam logic [7:0] ISC_ADDR_IMAG_LO = 8'h97;
   localparam logic [7:0] ISC_ADDR_CHECK = 8'h98;

   // Control word value after reset: power-down
   localparam logic [15:0] ISC_CTRL_RESET = 16'hA000;

   // Control word field positions
   localparam int ISC_CMD_MSB = 15;
   localparam int ISC_CMD_LSB = 11;
   localparam int ISC_CAL_BIT = 10;
   localparam int ISC_RANGE_MSB = 9;
   localparam int ISC_RANGE_LSB = 8;
   localparam int ISC_GAIN_BIT = 7;
   localparam int ISC_ERRCHK_BIT = 6;
   localparam int ISC_RSVD5_BIT = 5;
   localparam int ISC_RESET_BIT = 4;
   localparam int ISC_CLK_MSB = 3;
   localparam int ISC_CLK_LSB = 2;
   // Writable bits of the low byte; bits 5, 1 and 0 read as zero
   localparam logic [7:0] ISC_LO_MASK = 8'hDC;

   // Command field codes
   localparam logic [4:0] ISC_CMD_NOP = 5'h00;
   localparam logic [4:0] ISC_CMD_INIT = 5'h01;
   localparam logic [4:0] ISC_CMD_SWEEP = 5'h02;
   localparam logic [4:0] ISC_CMD_INC = 5'h03;
   localparam logic [4:0] ISC_CMD_REPEAT = 5'h04;
   localparam logic [4:0] ISC_CMD_RSVD = 5'h08;
   localparam logic [4:0] ISC_CMD_TEMP = 5'h09;
   localparam logic [4:0] ISC_CMD_PDOWN = 5'h0A;
   localparam logic [4:0] ISC_CMD_STBY = 5'h0B;

   // Range and clock select codes
   localparam logic [1:0] ISC_RANGE_FULL = 2'h0;
   localparam logic [1:0] ISC_RANGE_DIV10 = 2'h1;
   localparam logic [1:0] ISC_RANGE_DIV5 = 2'h2;
   localparam logic [1:0] ISC_RANGE_DIV2 = 2'h3;
   localparam logic [1:0] ISC_CLK_INTERNAL = 2'h0;
   localparam logic [1:0] ISC_CLK_RSVD = 2'h1;
   localparam logic [1:0] ISC_CLK_EXTERNAL = 2'h2;
   localparam logic [1:0] ISC_CLK_PLL = 2'h3;

   localparam int ISC_INDEX_W = 9;
   localparam int ISC_SETTLE_W = 9;

   // Analog and power steering
   typedef struct packed {
      logic excite_gnd;
      logic response_gnd;
      logic amp_pwr;
      logic osc_pwr;
      logic excite_en;
      logic adc_sample_en;
      logic temp_pwr;
   } isc_ana_t;

   // One-cycle events to the datapath
   typedef struct packed {
      logic freq_load_start;
      logic freq_step;
      logic meas_start;
      logic temp_start;
      logic soft_reset;
   } isc_evt_t;

   // Option fields of the control word
   typedef struct packed {
      logic cal_ext;
      logic [1:0] range_div;
      logic gain_x5;
      logic err_chk_en;
      logic [1:0] clk_sel;
   } isc_cfg_t;

   // Result words from the transform datapath
   typedef struct packed {
      logic [15:0] real_part;
      logic [15:0] imag_part;
   } isc_result_t;
endpackage : isc_pkg

// ---- rtl/isc_edge_sync.sv ----
// Two-flop synchroniser and rising-edge detector for the waveform clock
`timescale 1ns/100ps
module isc_edge_sync (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Asynchronous level
   input wire logic level_in,
   // Rising edge, one cycle
   output logic rise_out
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
      logic rise;
   } isc_sync_t;

   isc_sync_t s_r;
   isc_sync_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = level_in;
      s_nxt.sync = s_r.meta;
      s_nxt.last = s_r.sync;
      s_nxt.rise = s_r.sync & ~s_r.last;
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rise_out = s_r.rise;
endmodule : isc_edge_sync

// ---- rtl/isc_sweep_ctrl.sv ----
// Control word decoder and sweep command sequencer
`timescale 1ns/100ps
module isc_sweep_ctrl (
   // Clock and reset
   input wire logic CLK_SYS_IN,
   input wire logic RST_IN,
   // Register byte port from the serial engine
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   input wire logic [7:0] REG_ADDR_IN,
   input wire logic [7:0] REG_WDATA_IN,
   input wire logic REG_PEC_OK_IN,
   output logic [7:0] REG_RDATA_OUT,
   output logic REG_RVALID_OUT,
   // Datapath status
   input wire logic [isc_pkg::ISC_SETTLE_W-1:0] SETTLE_CYCLES_IN,
   input wire logic WAVE_CLK_IN,
   input wire isc_pkg::isc_result_t RESULT_IN,
   input wire logic RESULT_VALID_IN,
   input wire logic TEMP_DONE_IN,
   // Steering outputs
   output isc_pkg::isc_ana_t ANA_OUT,
   output isc_pkg::isc_evt_t EVT_OUT,
   output isc_pkg::isc_cfg_t CFG_OUT,
   output logic [isc_pkg::ISC_INDEX_W-1:0] FREQ_INDEX_OUT
);
   import isc_pkg::*;

   typedef enum logic [4:0] {
      SEQ_IDLE = 5'b00001,
      SEQ_EXCITE = 5'b00010,
      SEQ_SETTLE = 5'b00100,
      SEQ_SAMPLE = 5'b01000,
      SEQ_DONE = 5'b10000
   } isc_seq_t;

   typedef enum logic [2:0] {
      PWR_DOWN = 3'b001,
      PWR_STBY = 3'b010,
      PWR_ON = 3'b100
   } isc_pwr_t;

   typedef struct packed {
      logic [15:0] ctrl;
      isc_seq_t seq;
      isc_pwr_t pwr;
      logic temp_busy;
      logic [ISC_SETTLE_W-1:0] settle_cnt;
      logic [ISC_INDEX_W-1:0] index;
      isc_result_t result;
      logic [7:0] check;
      logic [7:0] rdata;
      logic rvalid;
      isc_ana_t ana;
      isc_evt_t evt;
      isc_cfg_t cfg;
   } isc_state_t;

   isc_state_t s_r;
   isc_state_t s_nxt;
   logic wave_rise;
   logic ctrl_hit;
   logic ctrl_wr_ok;
   logic [4:0] cmd;
   logic [7:0] lo_byte;

   isc_edge_sync u_wave_sync (
      .clk_in(CLK_SYS_IN),
      .rst_in(RST_IN),
      .level_in(WAVE_CLK_IN),
      .rise_out(wave_rise)
   );

   // Control writes rejected on a failed packet check while checking is on
   assign ctrl_hit = REG_WR_IN &&
      (REG_ADDR_IN == ISC_ADDR_CTRL_HI || REG_ADDR_IN == ISC_ADDR_CTRL_LO);
   assign ctrl_wr_ok = ctrl_hit && (!s_r.ctrl[ISC_ERRCHK_BIT] || REG_PEC_OK_IN);
   assign cmd = REG_WDATA_IN[7:3];
   assign lo_byte = REG_WDATA_IN & ISC_LO_MASK;

   always_comb begin
      s_nxt = s_r;
      s_nxt.evt = '0;
      s_nxt.rvalid = 1'b0;

      // Sequencer progress
      case (s_r.seq)
         SEQ_IDLE: begin
            s_nxt.seq = SEQ_IDLE;
         end
         SEQ_EXCITE: begin
            s_nxt.seq = SEQ_EXCITE;
         end
         SEQ_SETTLE: begin
            if (s_r.settle_cnt == '0) begin
               s_nxt.seq = SEQ_SAMPLE;
               s_nxt.evt.meas_start = 1'b1;
            end else if (wave_rise) begin
               s_nxt.settle_cnt = s_r.settle_cnt - 1'b1;
            end
         end
         SEQ_SAMPLE: begin
            if (RESULT_VALID_IN) begin
               s_nxt.seq = SEQ_DONE;
               s_nxt.result = RESULT_IN;
               s_nxt.check = RESULT_IN.real_part[15:8] + RESULT_IN.real_part[7:0] +
                  RESULT_IN.imag_part[15:8] + RESULT_IN.imag_part[7:0];
            end
         end
         SEQ_DONE: begin
            s_nxt.seq = SEQ_DONE;
         end
         default: begin
            s_nxt.seq = SEQ_IDLE;
         end
      endcase

      // Temperature block powers off once its reading is in
      if (s_r.temp_busy && TEMP_DONE_IN) begin
         s_nxt.temp_busy = 1'b0;
      end

      // Control high byte: store and act on the command field
      if (ctrl_wr_ok && REG_ADDR_IN == ISC_ADDR_CTRL_HI) begin
         s_nxt.ctrl[15:8] = REG_WDATA_IN;
         case (cmd)
            ISC_CMD_INIT: begin
               s_nxt.pwr = PWR_ON;
               s_nxt.seq = SEQ_EXCITE;
               s_nxt.index = '0;
               s_nxt.evt.freq_load_start = 1'b1;
            end
            ISC_CMD_SWEEP: begin
               s_nxt.pwr = PWR_ON;
               s_nxt.seq = SEQ_SETTLE;
               s_nxt.settle_cnt = SETTLE_CYCLES_IN;
            end
            ISC_CMD_INC: begin
               s_nxt.pwr = PWR_ON;
               s_nxt.seq = SEQ_SETTLE;
               s_nxt.settle_cnt = SETTLE_CYCLES_IN;
               s_nxt.index = s_r.index + 1'b1;
               s_nxt.evt.freq_step = 1'b1;
            end
            ISC_CMD_REPEAT: begin
               s_nxt.pwr = PWR_ON;
               s_nxt.seq = SEQ_SETTLE;
               s_nxt.settle_cnt = SETTLE_CYCLES_IN;
            end
            ISC_CMD_TEMP: begin
               if (!s_r.temp_busy) begin
                  s_nxt.temp_busy = 1'b1;
                  s_nxt.evt.temp_start = 1'b1;
               end
            end
            ISC_CMD_PDOWN: begin
               s_nxt.pwr = PWR_DOWN;
               s_nxt.seq = SEQ_IDLE;
            end
            ISC_CMD_STBY: begin
               s_nxt.pwr = PWR_STBY;
               s_nxt.seq = SEQ_IDLE;
            end
            default: begin
               s_nxt.pwr = s_r.pwr;
            end
         endcase
      end

      // Control low byte; the reset bit acts once and reads back zero
      if (ctrl_wr_ok && REG_ADDR_IN == ISC_ADDR_CTRL_LO) begin
         s_nxt.ctrl[7:0] = lo_byte & ~(8'h01 << ISC_RESET_BIT);
         if (lo_byte[ISC_RESET_BIT]) begin
            s_nxt.index = '0;
            s_nxt.seq = SEQ_IDLE;
            s_nxt.settle_cnt = '0;
            s_nxt.result = '0;
            s_nxt.check = '0;
            s_nxt.evt.soft_reset = 1'b1;
            s_nxt.evt.freq_load_start = 1'b1;
         end
      end

      // Register reads answer one cycle later
      if (REG_RD_IN) begin
         s_nxt.rvalid = 1'b1;
         case (REG_ADDR_IN)
            ISC_ADDR_CTRL_HI: s_nxt.rdata = s_r.ctrl[15:8];
            ISC_ADDR_CTRL_LO: s_nxt.rdata = s_r.ctrl[7:0];
            ISC_ADDR_INDEX_HI: s_nxt.rdata = {7'h00, s_r.index[8]};
            ISC_ADDR_INDEX_LO: s_nxt.rdata = s_r.index[7:0];
            ISC_ADDR_REAL_HI: s_nxt.rdata = s_r.result.real_part[15:8];
            ISC_ADDR_REAL_LO: s_nxt.rdata = s_r.result.real_part[7:0];
            ISC_ADDR_IMAG_HI: s_nxt.rdata = s_r.result.imag_part[15:8];
            ISC_ADDR_IMAG_LO: s_nxt.rdata = s_r.result.imag_part[7:0];
            ISC_ADDR_CHECK: s_nxt.rdata = s_r.check;
            default: s_nxt.rdata = 8'h00;
         endcase
      end

      // Power steering from the next power state
      case (s_nxt.pwr)
         PWR_DOWN: begin
            s_nxt.ana.amp_pwr = 1'b0;
            s_nxt.ana.osc_pwr = 1'b0;
            s_nxt.ana.excite_gnd = 1'b1;
            s_nxt.ana.response_gnd = 1'b1;
         end
         PWR_STBY: begin
            s_nxt.ana.amp_pwr = 1'b1;
            s_nxt.ana.osc_pwr = 1'b1;
            s_nxt.ana.excite_gnd = 1'b1;
            s_nxt.ana.response_gnd = 1'b1;
         end
         default: begin
            s_nxt.ana.amp_pwr = 1'b1;
            s_nxt.ana.osc_pwr = 1'b1;
            s_nxt.ana.excite_gnd = 1'b0;
            s_nxt.ana.response_gnd = 1'b0;
         end
      endcase
      s_nxt.ana.excite_en = (s_nxt.pwr == PWR_ON) && (s_nxt.seq != SEQ_IDLE);
      s_nxt.ana.adc_sample_en = (s_nxt.seq == SEQ_SAMPLE);
      s_nxt.ana.temp_pwr = s_nxt.temp_busy;

      // Option fields
      s_nxt.cfg.cal_ext = s_nxt.ctrl[ISC_CAL_BIT];
      s_nxt.cfg.range_div = s_nxt.ctrl[ISC_RANGE_MSB:ISC_RANGE_LSB];
      s_nxt.cfg.gain_x5 = ~s_nxt.ctrl[ISC_GAIN_BIT];
      s_nxt.cfg.err_chk_en = s_nxt.ctrl[ISC_ERRCHK_BIT];
      s_nxt.cfg.clk_sel = s_nxt.ctrl[ISC_CLK_MSB:ISC_CLK_LSB];
   end

   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         s_r <= '0;
         s_r.ctrl <= ISC_CTRL_RESET;
         s_r.seq <= SEQ_IDLE;
         s_r.pwr <= PWR_DOWN;
         s_r.ana.excite_gnd <= 1'b1;
         s_r.ana.response_gnd <= 1'b1;
         s_r.cfg.gain_x5 <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign REG_RDATA_OUT = s_r.rdata;
   assign REG_RVALID_OUT = s_r.rvalid;
   assign ANA_OUT = s_r.ana;
   assign EVT_OUT = s_r.evt;
   assign CFG_OUT = s_r.cfg;
   assign FREQ_INDEX_OUT = s_r.index;

   default clocking cb @(posedge CLK_SYS_IN);
   endclocking
   default disable iff (RST_IN);

   logic hi_ok;
   logic lo_ok;
   assign hi_ok = ctrl_wr_ok && REG_ADDR_IN == ISC_ADDR_CTRL_HI;
   assign lo_ok = ctrl_wr_ok && REG_ADDR_IN == ISC_ADDR_CTRL_LO;

   a_ctrl_reset: assert property ($past(RST_IN) && !$past(REG_WR_IN) |->
      s_r.ctrl == ISC_CTRL_RESET && ANA_OUT.excite_gnd && !ANA_OUT.osc_pwr)
      else $error("control word not at power-down value after reset");

   a_ctrl_hi_byte: assert property (hi_ok |=> s_r.ctrl[15:8] == $past(REG_WDATA_IN))
      else $error("high control byte not stored");

   a_init_excite: assert property (hi_ok && cmd == ISC_CMD_INIT |=>
      ANA_OUT.excite_en && FREQ_INDEX_OUT == '0 ##1 ANA_OUT.excite_en || $past(REG_WR_IN))
      else $error("initialize did not hold start frequency");

   a_settle_gate: assert property ($rose(ANA_OUT.adc_sample_en) |->
      $past(s_r.seq) == SEQ_SETTLE && $past(s_r.settle_cnt) == '0)
      else $error("sampling enabled before settling finished");

   a_inc_step: assert property (hi_ok && cmd == ISC_CMD_INC |=>
      EVT_OUT.freq_step && FREQ_INDEX_OUT == $past(s_r.index) + 9'h001)
      else $error("increment did not advance index");

   a_repeat_hold: assert property (hi_ok && cmd == ISC_CMD_REPEAT |=>
      !EVT_OUT.freq_step && $stable(FREQ_INDEX_OUT) && s_r.seq == SEQ_SETTLE)
      else $error("repeat changed frequency point");

   a_pdown_gnd: assert property (s_r.pwr == PWR_DOWN |->
      ANA_OUT.excite_gnd && ANA_OUT.response_gnd && !ANA_OUT.amp_pwr && !ANA_OUT.osc_pwr)
      else $error("power-down left a block powered or pin driven");

   a_stby_osc: assert property (hi_ok && cmd == ISC_CMD_STBY |=>
      ANA_OUT.amp_pwr && ANA_OUT.osc_pwr && ANA_OUT.excite_gnd && !ANA_OUT.excite_en)
      else $error("standby steering wrong");

   a_temp_self: assert property (hi_ok && cmd == ISC_CMD_TEMP && !s_r.temp_busy |=>
      EVT_OUT.temp_start && ANA_OUT.temp_pwr)
      else $error("temperature block not powered up");

   a_temp_off: assert property (s_r.temp_busy && TEMP_DONE_IN && !hi_ok |=>
      !ANA_OUT.temp_pwr)
      else $error("temperature block left powered");

   a_cfg_fields: assert property (CFG_OUT.range_div == s_r.ctrl[9:8] &&
      CFG_OUT.gain_x5 == !s_r.ctrl[7] && CFG_OUT.cal_ext == s_r.ctrl[10] &&
      CFG_OUT.clk_sel == s_r.ctrl[3:2] && s_r.ctrl[1:0] == 2'h0)
      else $error("option fields do not follow control word");

   a_pec_reject: assert property (ctrl_hit && s_r.ctrl[6] && !REG_PEC_OK_IN |=>
      $stable(s_r.ctrl) && !EVT_OUT.freq_step)
      else $error("control updated despite failed check");

   a_soft_reset: assert property (lo_ok && REG_WDATA_IN[4] |=>
      FREQ_INDEX_OUT == '0 && EVT_OUT.freq_load_start && s_r.seq == SEQ_IDLE && !s_r.ctrl[4])
      else $error("reset bit did not restart sweep");

   c_sweep_sample: cover property (hi_ok && cmd == ISC_CMD_SWEEP ##[1:100] ANA_OUT.adc_sample_en);
   c_result_done: cover property (ANA_OUT.adc_sample_en ##1 RESULT_VALID_IN);
   c_temp_cycle: cover property (EVT_OUT.temp_start ##[1:20] !ANA_OUT.temp_pwr);
   c_soft_reset: cover property (EVT_OUT.soft_reset);
endmodule : isc_sweep_ctrl

// ---- verification/isc_dp_model.sv ----
// Datapath model: waveform clock, result words and temperature reading
`timescale 1ns/100ps
module isc_dp_model
   import isc_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Steering from the sequencer
   input wire isc_pkg::isc_ana_t ana_in,
   input wire isc_pkg::isc_evt_t evt_in,
   // Datapath answers
   output logic wave_out,
   output isc_pkg::isc_result_t result_out,
   output logic rvalid_out,
   output logic tdone_out
);
   localparam isc_result_t RES = 32'h12F0A5C3;
   int mcnt;
   int tcnt;
   initial wave_out = 1'b0;
   // Waveform runs only while excitation is on, 160 ns period
   always begin
      #80;
      wave_out = ana_in.excite_en ? ~wave_out : 1'b0;
   end
   // Result lines show the fixed inverted pattern outside the valid pulse
   assign result_out = rvalid_out ? RES : ~RES;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mcnt <= 0;
         tcnt <= 0;
         rvalid_out <= 1'b0;
         tdone_out <= 1'b0;
      end else begin
         rvalid_out <= (mcnt == 1);
         tdone_out <= (tcnt == 1);
         mcnt <= evt_in.meas_start ? 20 : (mcnt > 0 ? mcnt - 1 : 0);
         tcnt <= evt_in.temp_start ? 12 : (tcnt > 0 ? tcnt - 1 : 0);
      end
   end
endmodule : isc_dp_model

// ---- verification/isc_sweep_ctrl_tb.sv ----
// Self-checking bench of the sweep control decoder
`timescale 1ns/100ps
module isc_sweep_ctrl_tb;
   import isc_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic wr = 1'b0, rd = 1'b0, pec = 1'b1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic rvalid, wave, res_v, t_done;
   logic [8:0] settle = 9'h000;
   logic [8:0] idx;
   logic [7:0] exp_res [5] = '{8'h12, 8'hF0, 8'hA5, 8'hC3, 8'h6A};
   isc_result_t res;
   isc_ana_t ana;
   isc_evt_t evt;
   isc_cfg_t cfg;
   int err_total = 0, comparisons = 0, rises = 0;
   always #5 clk = ~clk;
   always @(posedge wave) rises++;
   isc_sweep_ctrl dut (.CLK_SYS_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_PEC_OK_IN(pec), .REG_RDATA_OUT(rdata),
      .REG_RVALID_OUT(rvalid), .SETTLE_CYCLES_IN(settle), .WAVE_CLK_IN(wave),
      .RESULT_IN(res), .RESULT_VALID_IN(res_v), .TEMP_DONE_IN(t_done), .ANA_OUT(ana),
      .EVT_OUT(evt), .CFG_OUT(cfg), .FREQ_INDEX_OUT(idx));
   isc_dp_model model (.clk_in(clk), .rst_in(rst), .ana_in(ana), .evt_in(evt),
      .wave_out(wave), .result_out(res), .rvalid_out(res_v), .tdone_out(t_done));
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic wrb(input logic [7:0] a, input logic [7:0] d, input logic p = 1'b1);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      pec <= p;
      @(posedge clk);
      wr <= 1'b0;
      #1;
   endtask : wrb
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("rvalid", 16'(rvalid), 16'h0001);
      check("rdata", 16'(rdata), 16'(e));
   endtask : rdc
   task automatic waitb(input int s, input logic v);
      int n;
      for (n = 0; n < 2000; n++) begin
         if ((s == 0 ? ana.adc_sample_en : s == 1 ? ana.temp_pwr : evt.meas_start) === v)
            break;
         @(posedge clk);
         #1;
      end
      if (n == 2000) begin
         err_total++;
         $display("CHECK FAILED wait %0d expected %b seen timeout", s, v);
         end_sim();
      end
   endtask : waitb
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
      check("ana", 16'(ana), 16'h0060);
      check("cfg", 16'(cfg), 16'h0008);
      rdc(ISC_ADDR_CTRL_HI, 8'hA0);
      rdc(ISC_ADDR_CTRL_LO, 8'h00);
      rdc(8'h85, 8'h00);
      $display("Test reset done");
      for (int i = 0; i < 4; i++) begin
         wrb(ISC_ADDR_CTRL_HI, {ISC_CMD_NOP, i[0], i[1:0]});
         wrb(ISC_ADDR_CTRL_LO, {~i[0], 3'h0, i[1:0], 2'h0});
         check("range", 16'(cfg.range_div), 16'(i[1:0]));
         check("clk", 16'(cfg.clk_sel), 16'(i[1:0]));
         check("cal", 16'(cfg.cal_ext), 16'(i[0]));
         check("gain", 16'(cfg.gain_x5), 16'(i[0]));
         check("ana", 16'(ana), 16'h0060);
      end
      wrb(ISC_ADDR_CTRL_HI, 8'h58);
      check("ana", 16'(ana), 16'h0078);
      $display("Test options done");
      wrb(ISC_ADDR_CTRL_HI, 8'h08);
      check("load", 16'(evt.freq_load_start), 16'h0001);
      check("idx", 16'(idx), 16'h0000);
      repeat (50) @(posedge clk);
      #1;
      check("exc", 16'(ana.excite_en), 16'h0001);
      check("gnd", 16'(ana.excite_gnd), 16'h0000);
      for (int k = 1; k < 3; k++) begin
         wrb(ISC_ADDR_CTRL_HI, 8'h18);
         check("step", 16'(evt.freq_step), 16'h0001);
         check("idx", 16'(idx), 16'(k));
         waitb(0, 1'b1);
         waitb(0, 1'b0);
      end
      rdc(ISC_ADDR_INDEX_HI, 8'h00);
      rdc(ISC_ADDR_INDEX_LO, 8'h02);
      for (int j = 0; j < 5; j++)
         rdc(ISC_ADDR_REAL_HI + 8'(j), exp_res[j]);
      wrb(ISC_ADDR_CTRL_HI, 8'h20);
      check("step", 16'(evt.freq_step), 16'h0000);
      check("idx", 16'(idx), 16'h0002);
      waitb(0, 1'b1);
      waitb(0, 1'b0);
      $display("Test stepping done");
      wrb(ISC_ADDR_CTRL_HI, 8'h48);
      check("tstart", 16'(evt.temp_start), 16'h0001);
      check("tpwr", 16'(ana.temp_pwr), 16'h0001);
      waitb(1, 1'b0);
      check("amp", 16'(ana.amp_pwr), 16'h0001);
      wrb(ISC_ADDR_CTRL_HI, 8'h50);
      check("ana", 16'(ana), 16'h0060);
      wrb(ISC_ADDR_CTRL_HI, 8'h48);
      check("tpwr", 16'(ana), 16'h0061);
      waitb(1, 1'b0);
      check("ana", 16'(ana), 16'h0060);
      @(posedge clk);
      settle <= 9'd3;
      rises = 0;
      wrb(ISC_ADDR_CTRL_HI, 8'h10);
      check("adc", 16'(ana.adc_sample_en), 16'h0000);
      waitb(2, 1'b1);
      check("adc", 16'(ana.adc_sample_en), 16'h0001);
      check("rises", 16'(rises), 16'h0003);
      waitb(0, 1'b0);
      $display("Test sweep done");
      wrb(ISC_ADDR_CTRL_LO, 8'h40);
      check("errchk", 16'(cfg.err_chk_en), 16'h0001);
      wrb(ISC_ADDR_CTRL_HI, 8'h58, 1'b0);
      rdc(ISC_ADDR_CTRL_HI, 8'h10);
      wrb(ISC_ADDR_CTRL_HI, 8'h58);
      rdc(ISC_ADDR_CTRL_HI, 8'h58);
      wrb(ISC_ADDR_CTRL_LO, 8'h50);
      check("srst", 16'(evt.soft_reset), 16'h0001);
      check("idx", 16'(idx), 16'h0000);
      check("load", 16'(evt.freq_load_start), 16'h0001);
      rdc(ISC_ADDR_CTRL_LO, 8'h40);
      rdc(ISC_ADDR_REAL_HI, 8'h00);
      $display("Test check and reset done");
      end_sim();
   end
endmodule : isc_sweep_ctrl_tb
